// file: verilog/mode_defaults_pkg.sv
package mode_defaults_pkg;

    typedef enum logic [4:0] {
        MODE_STANDBY  = 5'h01,
        MODE_NORMAL   = 5'h02,
        MODE_SLEEP    = 5'h04,
        MODE_OVERTEMP = 5'h08,
        MODE_RESET    = 5'h10
    } op_mode_t;

    localparam logic [2:0] OPM_STANDBY   = 3'h4;
    localparam logic [2:0] OPM_NORMAL    = 3'h7;
    localparam logic [2:0] OPM_SLEEP     = 3'h1;
    localparam logic [2:0] OPM_POWERON   = 3'h4;
    localparam logic [3:0] WDP_DEFAULT   = 4'h4;
    localparam logic [1:0] CNT_LIMIT     = 2'h3;
    localparam logic [4:0] SRC_POWERON   = 5'h00;
    localparam logic [4:0] SRC_OVERTEMP  = 5'h12;
    localparam logic [7:0] MASK_DEFAULT  = 8'hFF;
    localparam logic [7:0] BYTE_CLEAR    = 8'h00;
    localparam logic [3:0] DLC_CLEAR     = 4'h0;
    localparam int         MASK_BYTES    = 8;
    localparam int         SCRATCH_BYTES = 4;
    localparam int         ID_BYTES      = 4;

endpackage : mode_defaults_pkg

// file: verilog/byte_bank.sv
`timescale 1ns/1ps
// Small byte store whose read data leave a register; reset loads every entry with INIT.
module byte_bank #(
    parameter int         DEPTH = 8,
    parameter logic [7:0] INIT  = 8'h00
) (
    input  wire logic                     sys_clk,
    input  wire logic                     rst_n,
    input  wire logic                     wrEn,
    input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
    input  wire logic [7:0]               wrData,
    input  wire logic [$clog2(DEPTH)-1:0] rdAddr,
    output logic      [7:0]               rdData
);
    logic [7:0] mem [DEPTH];

    initial begin
        if (DEPTH < 2) begin
            $error("byte_bank depth must be at least two");
        end
    end

    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (!rst_n) begin
                mem[i] <= INIT;
            end else if (wrEn && wrAddr == i[$clog2(DEPTH)-1:0]) begin
                mem[i] <= wrData;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rdData <= INIT;
        end else begin
            rdData <= mem[rdAddr];
        end
    end
endmodule : byte_bank

// file: verilog/mode_dependent_register_defaults.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE1 - Mode field: 100 at power-on, Standby, Reset; 111 Normal; 001 Sleep.
// RULE2 - Normal status bit is 1 at power-on and cleared on entering Normal.
// RULE3 - Transceiver status shows live state only in Normal, else reads 0.
// RULE4 - Watchdog period reloads 0100 at power-on and on Overtemp or Reset entry.
// RULE5 - Limp-home clears at power-on; set after limp delay in Overtemp or Reset, or in Reset with counter 3.
// RULE6 - Reset counter clears at power-on and increments on each Reset entry.
// RULE7 - Reset source clears at power-on, loads 10010 on Overtemp, source on Reset.
// RULE8 - Power-on and system event flags set at power-on, kept on mode changes.
// RULE9 - Bus wake, overtemp, serial failure, supply flags clear at power-on, then kept.
// RULE10 - Event enable bits clear at power-on and keep host values thereafter.
// RULE11 - Four live status bits read 0 at power-on, then follow live conditions.
// RULE12 - Non-volatile ECC and programmed status always follow live conditions.
// RULE13 - Configuration fields always show the non-volatile stored values.
// RULE14 - Data byte masks start at all ones and keep host-written values.
// RULE15 - Scratch, identifier, CRC bytes and DLC clear at power-on, then kept.
// RULE16 - Data match set, config-ok and FD error cleared at power-on, then kept.
// RULE17 - Lock bits, IDE and decoder config clear at power-on, then kept.
// RULE18 - A host write coinciding with a mode entry is dropped; host must repeat.
// RULE19 - All mode-entry updates land in the cycle the new mode becomes active.
module mode_dependent_register_defaults
    import mode_defaults_pkg::*;
#(
    parameter int MASK_N    = mode_defaults_pkg::MASK_BYTES,
    parameter int SCRATCH_N = mode_defaults_pkg::SCRATCH_BYTES
) (
    input  wire logic                          sys_clk,
    input  wire logic                          rst_n,
    input  wire logic                          modeEntry,
    input  wire mode_defaults_pkg::op_mode_t   nextMode,
    input  wire logic                          limpDelayDone,
    input  wire logic [4:0]                    resetSource,
    input  wire logic                          liveTrx,
    input  wire logic                          liveOvertempWarn,
    input  wire logic                          liveForcedNormal,
    input  wire logic                          liveSoftwareDev,
    input  wire logic                          livePnConfig,
    input  wire logic                          liveNvEcc,
    input  wire logic                          liveNvProgrammed,
    input  wire logic                          nvForcedNormal,
    input  wire logic [1:0]                    nvResetLength,
    input  wire logic                          nvSoftwareDev,
    input  wire logic                          nvSleepControl,
    input  wire logic                          evBusWake,
    input  wire logic                          evOvertempWarn,
    input  wire logic                          evSerialFail,
    input  wire logic                          evSupply,
    input  wire logic                          evClear,
    input  wire logic                          wrWatchdog,
    input  wire logic [3:0]                    wrWatchdogData,
    input  wire logic                          wrEnables,
    input  wire logic [2:0]                    wrEnablesData,
    input  wire logic                          wrMask,
    input  wire logic [$clog2(MASK_N)-1:0]     maskAddr,
    input  wire logic                          wrScratch,
    input  wire logic [$clog2(SCRATCH_N)-1:0]  scratchAddr,
    input  wire logic                          wrFrame,
    input  wire logic [7:0]                    wrData,
    input  wire logic [1:0]                    idAddr,
    input  wire logic                          wrMisc,
    input  wire logic [5:0]                    wrMiscData,
    output logic      [2:0]                    operating_mode_field,
    output logic                               normal_mode_status,
    output logic                               trxStatus,
    output logic      [3:0]                    watchdog_period_field,
    output logic                               limp_home_control,
    output logic      [1:0]                    reset_counter,
    output logic      [4:0]                    reset_source_status,
    output logic                               power_on_flag,
    output logic                               system_event_summary,
    output logic                               bus_wake_flag,
    output logic                               overtemp_warning_flag,
    output logic                               serial_failure_flag,
    output logic                               supply_event_summary,
    output logic                               bus_wake_enable,
    output logic                               overtemp_warning_enable,
    output logic                               serial_failure_enable,
    output logic                               overtemp_warning_status,
    output logic                               forced_normal_status,
    output logic                               software_dev_status,
    output logic                               pn_config_status,
    output logic                               nv_ecc_status,
    output logic                               nv_programmed_status,
    output logic                               forced_normal_config,
    output logic      [1:0]                    reset_length_config,
    output logic                               software_dev_config,
    output logic                               sleep_control_config,
    output logic      [7:0]                    data_byte_mask,
    output logic      [7:0]                    scratch_memory_byte,
    output logic      [7:0]                    frame_id_byte,
    output logic      [7:0]                    nv_crc_value,
    output logic      [3:0]                    frameDlc,
    output logic                               frameIde,
    output logic                               pn_data_match_bit,
    output logic                               pn_config_ok,
    output logic                               pn_fd_error_flag,
    output logic      [1:0]                    lock_control,
    output logic                               pn_decoder_config
);
    import mode_defaults_pkg::*;

    initial begin
        if (MASK_N < 2 || SCRATCH_N < 2) begin
            $error("mask and scratch banks need at least two bytes");
        end
    end

    op_mode_t   mode;
    logic       hostOk;
    logic [7:0] idBytes [ID_BYTES];
    op_mode_t   nowMode;

    // Host writes landing with a mode entry are lost on purpose, so entry values win.
    assign hostOk = !modeEntry; // RULE18

    // The live bit follows the mode being entered, so it changes with the mode field.
    assign nowMode = modeEntry ? nextMode : mode; // RULE19

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mode <= MODE_STANDBY;
        end else if (modeEntry) begin
            mode <= nextMode;
        end
    end

    // Every entry effect is applied on the same edge that updates mode.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            operating_mode_field <= OPM_POWERON; // RULE1
            normal_mode_status   <= 1'b1; // RULE2
            reset_counter        <= 2'h0; // RULE6
            reset_source_status  <= SRC_POWERON; // RULE7
        end else if (modeEntry) begin // RULE19
            case (nextMode)
                MODE_STANDBY: begin
                    operating_mode_field <= OPM_STANDBY; // RULE1
                end
                MODE_NORMAL: begin
                    operating_mode_field <= OPM_NORMAL; // RULE1
                    normal_mode_status   <= 1'b0; // RULE2
                end
                MODE_SLEEP: begin
                    operating_mode_field <= OPM_SLEEP; // RULE1
                end
                MODE_OVERTEMP: begin
                    reset_source_status <= SRC_OVERTEMP; // RULE7
                end
                MODE_RESET: begin
                    operating_mode_field <= OPM_STANDBY; // RULE1
                    reset_counter        <= reset_counter + 2'h1; // RULE6
                    reset_source_status  <= resetSource; // RULE7
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            watchdog_period_field <= WDP_DEFAULT; // RULE4
        end else if (modeEntry && (nextMode == MODE_OVERTEMP || nextMode == MODE_RESET)) begin
            watchdog_period_field <= WDP_DEFAULT; // RULE4
        end else if (wrWatchdog && hostOk) begin
            watchdog_period_field <= wrWatchdogData;
        end
    end

    // The counter is compared after the Reset entry has incremented it.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            limp_home_control <= 1'b0; // RULE5
        end else if (mode == MODE_OVERTEMP && limpDelayDone) begin
            limp_home_control <= 1'b1; // RULE5
        end else if (mode == MODE_RESET && (limpDelayDone || reset_counter == CNT_LIMIT)) begin
            limp_home_control <= 1'b1; // RULE5
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            trxStatus               <= 1'b0;
            overtemp_warning_status <= 1'b0;
            forced_normal_status    <= 1'b0;
            software_dev_status     <= 1'b0;
            pn_config_status        <= 1'b0;
        end else begin
            trxStatus               <= (nowMode == MODE_NORMAL) && liveTrx; // RULE3
            overtemp_warning_status <= liveOvertempWarn; // RULE11
            forced_normal_status    <= liveForcedNormal; // RULE11
            software_dev_status     <= liveSoftwareDev; // RULE11
            pn_config_status        <= livePnConfig; // RULE11
        end
    end

    // These follow live sources with no reset override, as they mirror the store.
    always_ff @(posedge sys_clk) begin
        nv_ecc_status        <= liveNvEcc; // RULE12
        nv_programmed_status <= liveNvProgrammed; // RULE12
        forced_normal_config <= nvForcedNormal; // RULE13
        reset_length_config  <= nvResetLength; // RULE13
        software_dev_config  <= nvSoftwareDev; // RULE13
        sleep_control_config <= nvSleepControl; // RULE13
    end

    // Event set wins over a host clear in the same cycle.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            power_on_flag         <= 1'b1; // RULE8
            system_event_summary  <= 1'b1; // RULE8
            bus_wake_flag         <= 1'b0; // RULE9
            overtemp_warning_flag <= 1'b0; // RULE9
            serial_failure_flag   <= 1'b0; // RULE9
            supply_event_summary  <= 1'b0; // RULE9
        end else begin
            power_on_flag         <= power_on_flag && !(evClear && hostOk);
            system_event_summary  <= evOvertempWarn || evSerialFail
                                     || (system_event_summary && !(evClear && hostOk));
            bus_wake_flag         <= evBusWake || (bus_wake_flag && !(evClear && hostOk));
            overtemp_warning_flag <= evOvertempWarn
                                     || (overtemp_warning_flag && !(evClear && hostOk));
            serial_failure_flag   <= evSerialFail
                                     || (serial_failure_flag && !(evClear && hostOk));
            supply_event_summary  <= evSupply
                                     || (supply_event_summary && !(evClear && hostOk));
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bus_wake_enable         <= 1'b0; // RULE10
            overtemp_warning_enable <= 1'b0; // RULE10
            serial_failure_enable   <= 1'b0; // RULE10
        end else if (wrEnables && hostOk) begin
            bus_wake_enable         <= wrEnablesData[0]; // RULE10
            overtemp_warning_enable <= wrEnablesData[1];
            serial_failure_enable   <= wrEnablesData[2];
        end
    end

    byte_bank #(.DEPTH(MASK_N), .INIT(MASK_DEFAULT)) maskBank ( // RULE14
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .wrEn    (wrMask && hostOk),
        .wrAddr  (maskAddr),
        .wrData  (wrData),
        .rdAddr  (maskAddr),
        .rdData  (data_byte_mask)
    );

    byte_bank #(.DEPTH(SCRATCH_N), .INIT(BYTE_CLEAR)) scratchBank ( // RULE15
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .wrEn    (wrScratch && hostOk),
        .wrAddr  (scratchAddr),
        .wrData  (wrData),
        .rdAddr  (scratchAddr),
        .rdData  (scratch_memory_byte)
    );

    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < ID_BYTES; i++) begin
            if (!rst_n) begin
                idBytes[i] <= BYTE_CLEAR; // RULE15
            end else if (wrFrame && hostOk && idAddr == i[1:0]) begin
                idBytes[i] <= wrData;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            frame_id_byte <= BYTE_CLEAR;
        end else begin
            frame_id_byte <= idBytes[idAddr];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            nv_crc_value      <= BYTE_CLEAR; // RULE15
            frameDlc          <= DLC_CLEAR; // RULE15
            frameIde          <= 1'b0; // RULE17
            pn_data_match_bit <= 1'b1; // RULE16
            pn_config_ok      <= 1'b0; // RULE16
            pn_fd_error_flag  <= 1'b0; // RULE16
            lock_control      <= 2'h0; // RULE17
            pn_decoder_config <= 1'b0; // RULE17
        end else if (wrMisc && hostOk) begin
            frameDlc          <= wrMiscData[3:0];
            frameIde          <= wrMiscData[4];
            pn_data_match_bit <= wrMiscData[5];
            nv_crc_value      <= wrData;
            lock_control      <= wrMiscData[1:0];
            pn_decoder_config <= wrMiscData[2];
            pn_config_ok      <= wrMiscData[3];
            pn_fd_error_flag  <= pn_fd_error_flag && !wrMiscData[4];
        end
    end

    sequence enterNormal_s;
        modeEntry && nextMode == MODE_NORMAL;
    endsequence

    sequence enterSleep_s;
        modeEntry && nextMode == MODE_SLEEP;
    endsequence

    sequence enterReset_s;
        modeEntry && nextMode == MODE_RESET;
    endsequence

    sequence enterOvertemp_s;
        modeEntry && nextMode == MODE_OVERTEMP;
    endsequence

    entry_normal_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE1
        enterNormal_s |=> operating_mode_field == OPM_NORMAL && !normal_mode_status)
        else $error("normal entry values wrong");
    entry_sleep_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE1
        enterSleep_s |=> operating_mode_field == OPM_SLEEP)
        else $error("sleep mode field wrong");
    trx_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE3
        nowMode != MODE_NORMAL |=> !trxStatus)
        else $error("trx status leaked");
    wdp_reload_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE4
        enterReset_s |=> watchdog_period_field == WDP_DEFAULT)
        else $error("watchdog period not reloaded");
    limp_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE5
        mode == MODE_OVERTEMP && limpDelayDone |=> limp_home_control)
        else $error("limp home not set");
    rcc_inc_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE6
        enterReset_s |=> reset_counter == $past(reset_counter) + 2'h1)
        else $error("reset counter not incremented");
    rss_ot_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE7
        enterOvertemp_s |=> reset_source_status == SRC_OVERTEMP)
        else $error("overtemp source code wrong");
    wake_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE9
        evBusWake |=> bus_wake_flag)
        else $error("bus wake event lost");
    drop_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE18
        modeEntry && (wrEnables || wrWatchdog) && nextMode != MODE_RESET
        && nextMode != MODE_OVERTEMP |=> $stable({bus_wake_enable, watchdog_period_field}))
        else $error("write during mode entry taken");
endmodule : mode_dependent_register_defaults

// file: tb/host_model.sv
`timescale 1ns/1ps
module host_model (
    input  wire logic       sys_clk,
    input  wire logic       modeEntry,
    output logic            wrWatchdog,
    output logic [3:0]      wrWatchdogData,
    output logic            wrEnables,
    output logic [2:0]      wrEnablesData,
    output logic            wrMask,
    output logic [2:0]      maskAddr,
    output logic            wrScratch,
    output logic [1:0]      scratchAddr,
    output logic            wrFrame,
    output logic [1:0]      idAddr,
    output logic            wrMisc,
    output logic [5:0]      wrMiscData,
    output logic [7:0]      wrData
);
    logic [5:0] strobe;
    logic       dropped;
    assign {wrMisc, wrFrame, wrScratch, wrMask, wrEnables, wrWatchdog} = strobe;
    initial begin
        strobe = 6'h00;
        {wrData, wrMiscData, wrWatchdogData, wrEnablesData} = 21'h00000;
        {maskAddr, scratchAddr, idAddr} = 7'h00;
    end
    // Kinds: 0 watchdog, 1 enables, 2 mask, 3 scratch, 4 frame, 5 misc.
    // Released data lines flip so that a stale value is never mistaken for a write.
    task automatic access(input int kind, input logic [7:0] d, input logic [5:0] m,
                          input bit retry);
        do begin
            @(negedge sys_clk);
            {wrData, wrMiscData, wrWatchdogData, wrEnablesData} = {d, m, d[3:0], d[2:0]};
            strobe = 6'h01 << kind;
            @(posedge sys_clk);
            dropped = modeEntry;
            @(negedge sys_clk);
            strobe = 6'h00;
            {wrData, wrMiscData, wrWatchdogData, wrEnablesData} = ~{d, m, d[3:0], d[2:0]};
        end while (dropped && retry);
    endtask : access
    task automatic point(input logic [2:0] ma, input logic [1:0] sa, input logic [1:0] ia);
        @(negedge sys_clk);
        {maskAddr, scratchAddr, idAddr} = {ma, sa, ia};
        repeat (2) @(negedge sys_clk);
    endtask : point
endmodule : host_model

// file: tb/mode_dependent_register_defaults_tb_top.sv
`timescale 1ns/1ps
module mode_dependent_register_defaults_tb_top;
    import mode_defaults_pkg::*;
    logic sys_clk, rst_n, modeEntry, limpDelayDone, liveTrx, liveOvertempWarn;
    logic liveForcedNormal, liveSoftwareDev, livePnConfig, liveNvEcc, liveNvProgrammed;
    logic nvForcedNormal, nvSoftwareDev, nvSleepControl, evClear;
    logic evBusWake, evOvertempWarn, evSerialFail, evSupply;
    logic [1:0] nvResetLength, scratchAddr, idAddr, reset_counter;
    logic [1:0] reset_length_config, lock_control;
    logic [4:0] resetSource, reset_source_status;
    op_mode_t nextMode;
    logic wrWatchdog, wrEnables, wrMask, wrScratch, wrFrame, wrMisc;
    logic [3:0] wrWatchdogData, watchdog_period_field, frameDlc;
    logic [2:0] wrEnablesData, maskAddr, operating_mode_field;
    logic [5:0] wrMiscData;
    logic [7:0] wrData, data_byte_mask, scratch_memory_byte, frame_id_byte, nv_crc_value;
    logic normal_mode_status, trxStatus, limp_home_control, power_on_flag;
    logic system_event_summary, bus_wake_flag, overtemp_warning_flag, serial_failure_flag;
    logic supply_event_summary, bus_wake_enable, overtemp_warning_enable;
    logic serial_failure_enable, overtemp_warning_status, forced_normal_status;
    logic software_dev_status, pn_config_status, nv_ecc_status, nv_programmed_status;
    logic forced_normal_config, software_dev_config, sleep_control_config, frameIde;
    logic pn_data_match_bit, pn_config_ok, pn_fd_error_flag, pn_decoder_config;
    int failures, n_tests;
    wire [16:0] modeView = {operating_mode_field, normal_mode_status, trxStatus,
        watchdog_period_field, limp_home_control, reset_counter, reset_source_status};
    wire [5:0] flagView = {power_on_flag, system_event_summary, bus_wake_flag,
        overtemp_warning_flag, serial_failure_flag, supply_event_summary};
    wire [2:0] enView = {serial_failure_enable, overtemp_warning_enable, bus_wake_enable};
    wire [3:0] stView = {overtemp_warning_status, forced_normal_status, software_dev_status,
        pn_config_status};
    wire [6:0] nvView = {nv_ecc_status, nv_programmed_status, forced_normal_config,
        reset_length_config, software_dev_config, sleep_control_config};
    wire [18:0] frView = {frameDlc, frameIde, pn_data_match_bit, nv_crc_value, lock_control,
        pn_decoder_config, pn_config_ok, pn_fd_error_flag};
    wire [23:0] byteView = {data_byte_mask, scratch_memory_byte, frame_id_byte};
    op_mode_t modes[7] = '{MODE_STANDBY, MODE_NORMAL, MODE_SLEEP, MODE_OVERTEMP,
        MODE_RESET, MODE_STANDBY, MODE_RESET};
    logic [16:0] expView[7] = '{
        {OPM_STANDBY, 1'b1, 1'b0, 4'hA, 1'b0, 2'h0, 5'h00},
        {OPM_NORMAL, 1'b0, 1'b1, 4'hA, 1'b0, 2'h0, 5'h00},
        {OPM_SLEEP, 1'b0, 1'b0, 4'hA, 1'b0, 2'h0, 5'h00},
        {OPM_SLEEP, 1'b0, 1'b0, WDP_DEFAULT, 1'b0, 2'h0, SRC_OVERTEMP},
        {OPM_STANDBY, 1'b0, 1'b0, WDP_DEFAULT, 1'b0, 2'h1, 5'h05},
        {OPM_STANDBY, 1'b0, 1'b0, WDP_DEFAULT, 1'b0, 2'h1, 5'h05},
        {OPM_STANDBY, 1'b0, 1'b0, WDP_DEFAULT, 1'b0, 2'h2, 5'h05}};
    mode_dependent_register_defaults uut (.*);
    host_model host (.*);
    always #5 sys_clk = ~sys_clk;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic enter(input op_mode_t m);
        @(negedge sys_clk);
        modeEntry = 1'b1;
        nextMode = m;
        @(negedge sys_clk);
        modeEntry = 1'b0;
    endtask : enter
    task automatic complete_run();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run
    // The tests need fewer than a hundred cycles; ten thousand leaves ample margin.
    initial begin
        #100000;
        failures++;
        complete_run();
    end
    initial begin
        sys_clk = 1'b0;
        rst_n = 1'b0;
        failures = 0;
        n_tests = 0;
        nextMode = MODE_STANDBY;
        resetSource = 5'h05;
        {modeEntry, limpDelayDone, evBusWake, evOvertempWarn, evSerialFail} = 5'h00;
        {evSupply, evClear} = 2'h0;
        {liveTrx, liveOvertempWarn, liveForcedNormal, liveSoftwareDev, livePnConfig} = 5'h1F;
        {liveNvEcc, liveNvProgrammed, nvForcedNormal, nvResetLength, nvSoftwareDev,
            nvSleepControl} = 7'h55;
        repeat (10) @(negedge sys_clk);
        check("mode bits", modeView, {OPM_POWERON, 1'b1, 1'b0, WDP_DEFAULT, 1'b0, 2'h0,
            SRC_POWERON});
        check("event flags", flagView, 6'h30);
        check("enables", enView, 3'h0);
        check("live status", stView, 4'h0);
        check("nv mirrors", nvView, 7'h55);
        check("frame bits", frView, {DLC_CLEAR, 2'h1, BYTE_CLEAR, 5'h00});
        rst_n = 1'b1;
        repeat (2) @(negedge sys_clk);
        check("live status", stView, 4'hF);
        host.point(3'h0, 2'h0, 2'h0);
        check("bytes", byteView, {MASK_DEFAULT, BYTE_CLEAR, BYTE_CLEAR});
        host.point(3'h7, 2'h3, 2'h2);
        host.access(0, 8'h0A, 6'h00, 1'b1);
        host.access(1, 8'h05, 6'h00, 1'b1);
        host.access(2, 8'h3C, 6'h00, 1'b1);
        host.access(3, 8'hA5, 6'h00, 1'b1);
        host.access(4, 8'h5A, 6'h00, 1'b1);
        host.access(5, 8'hC3, 6'h1B, 1'b1);
        {evBusWake, evOvertempWarn, evSerialFail, evSupply} = 4'hF;
        @(negedge sys_clk);
        {evBusWake, evOvertempWarn, evSerialFail, evSupply} = 4'h0;
        for (int i = 0; i < 7; i++) begin
            enter(modes[i]);
            check("mode entry", modeView, expView[i]);
        end
        check("event flags", flagView, 6'h3F);
        {evClear, evBusWake} = 2'h3;
        @(negedge sys_clk);
        {evClear, evBusWake} = 2'h0;
        check("event clear", flagView, 6'h08);
        check("enables", enView, 3'h5);
        check("frame bits", frView, {4'hB, 1'b1, 1'b0, 8'hC3, 2'h3, 3'h2});
        check("bytes", byteView, 24'h3CA55A);
        {liveOvertempWarn, liveForcedNormal, liveSoftwareDev, livePnConfig} = 4'h0;
        {liveNvEcc, liveNvProgrammed, nvForcedNormal, nvResetLength, nvSoftwareDev,
            nvSleepControl} = 7'h2A;
        repeat (2) @(negedge sys_clk);
        check("live status", stView, 4'h0);
        check("nv mirrors", nvView, 7'h2A);
        enter(MODE_RESET);
        check("reset count", reset_counter, CNT_LIMIT);
        repeat (2) @(negedge sys_clk);
        check("limp", limp_home_control, 1'b1);
        fork
            enter(MODE_NORMAL);
            host.access(0, 8'h09, 6'h00, 1'b0);
        join
        check("dropped write", watchdog_period_field, WDP_DEFAULT);
        fork
            enter(MODE_SLEEP);
            host.access(0, 8'h09, 6'h00, 1'b1);
        join
        check("repeated write", watchdog_period_field, 4'h9);
        rst_n = 1'b0;
        @(negedge sys_clk);
        rst_n = 1'b1;
        limpDelayDone = 1'b1;
        enter(MODE_STANDBY);
        repeat (2) @(negedge sys_clk);
        check("limp", limp_home_control, 1'b0);
        check("event flags", flagView, 6'h30);
        enter(MODE_OVERTEMP);
        repeat (2) @(negedge sys_clk);
        check("limp", limp_home_control, 1'b1);
        check("source", {reset_counter, reset_source_status}, {2'h0, SRC_OVERTEMP});
        complete_run();
    end
endmodule : mode_dependent_register_defaults_tb_top
